// ### rtl/legacy_decode_pkg.sv
package legacy_decode_pkg;
   localparam logic [7:0] OFS_PM_IO_WINDOW_BASE = 8'h78;
   localparam logic [7:0] OFS_ATTR_F_SEGMENT = 8'h90;
   localparam logic [7:0] OFS_ATTR_C_LOW = 8'h91;
   localparam logic [31:0] RST_PM_IO_WINDOW_BASE = 32'h0000_0000;
   localparam logic [7:0] RST_ATTR = 8'h00;
   localparam logic [31:0] MASK_PM_IO_WINDOW_BASE = 32'h0000_ffc1;
   localparam logic [7:0] MASK_ATTR_F_SEGMENT = 8'h30;
   localparam logic [7:0] MASK_ATTR_C_LOW = 8'h33;
   localparam int POS_WIN_EN = 0;
   localparam int POS_UPPER = 4;
   localparam int POS_LOWER = 0;
   localparam logic [31:0] REGION_LO = 32'h000c_0000;
   localparam logic [31:0] REGION_HI = 32'h000f_ffff;
   localparam logic [15:0] SEG_F_BASE = 16'h000f;
   localparam logic [17:0] SEG_C0_BASE = 18'h00030;
   localparam logic [17:0] SEG_C4_BASE = 18'h00031;

   typedef enum logic [1:0] {SRC_CPU = 2'h0, SRC_PCI = 2'h1, SRC_LINK = 2'h2, SRC_GFX = 2'h3}
      source_e;
   typedef enum logic [1:0] {DST_NONE = 2'h0, DST_DRAM = 2'h1, DST_DOWN = 2'h2}
      target_e;

   typedef struct packed {
      logic valid;
      logic is_io;
      logic is_write;
      source_e source;
      logic [31:0] addr;
   } access_s;

   typedef struct packed {
      logic valid;
      target_e target;
      logic pm_io_hit;
   } route_s;
endpackage

// ### rtl/legacy_region_attribute_decode.sv
`timescale 1ns/10ps
module legacy_region_attribute_decode
   import legacy_decode_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [3:0] CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   input wire access_s ACC,
   output route_s ROUTE
);
   logic [31:0] pm_io_window_base_ff, nxt_pm_io_window_base;
   logic [7:0] legacy_attr_map_f_segment_ff, nxt_legacy_attr_map_f_segment;
   logic [7:0] legacy_attr_map_c_low_ff, nxt_legacy_attr_map_c_low;
   logic [31:0] cfg_rdata_ff, nxt_cfg_rdata;
   route_s route_ff, nxt_route;

   // Byte-lane merge; masks keep reserved bits at zero
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r & mask;
   endfunction

   // Field steering: bit 0 claims reads, bit 1 claims writes
   function automatic target_e steer(input logic [1:0] attr, input logic is_write);
      return (is_write ? attr[1] : attr[0]) ? DST_DRAM : DST_DOWN;
   endfunction

   // Config writes; one write may set base and enable together
   always_comb
   begin
      nxt_pm_io_window_base = pm_io_window_base_ff;
      nxt_legacy_attr_map_f_segment = legacy_attr_map_f_segment_ff;
      nxt_legacy_attr_map_c_low = legacy_attr_map_c_low_ff;
      if (CFG_WR && CFG_ADDR == OFS_PM_IO_WINDOW_BASE)
      begin
         nxt_pm_io_window_base = merge(pm_io_window_base_ff, CFG_WDATA, CFG_BE,
                                       MASK_PM_IO_WINDOW_BASE);
      end
      // At the dword-aligned offset the F register takes lane 0 and the C low register lane 1
      if (CFG_WR && CFG_ADDR == OFS_ATTR_F_SEGMENT && CFG_BE[0])
      begin
         nxt_legacy_attr_map_f_segment = CFG_WDATA[7:0] & MASK_ATTR_F_SEGMENT;
      end
      if (CFG_WR && CFG_ADDR == OFS_ATTR_F_SEGMENT && CFG_BE[1])
      begin
         nxt_legacy_attr_map_c_low = CFG_WDATA[15:8] & MASK_ATTR_C_LOW;
      end
      if (CFG_WR && CFG_ADDR == OFS_ATTR_C_LOW && CFG_BE[0])
      begin
         nxt_legacy_attr_map_c_low = CFG_WDATA[7:0] & MASK_ATTR_C_LOW;
      end
   end

   // Read mux; unmapped offsets return zero
   always_comb
   begin
      nxt_cfg_rdata = cfg_rdata_ff;
      if (CFG_RD)
      begin
         case (CFG_ADDR)
            OFS_PM_IO_WINDOW_BASE: nxt_cfg_rdata = pm_io_window_base_ff;
            OFS_ATTR_F_SEGMENT: nxt_cfg_rdata = {16'h0000, legacy_attr_map_c_low_ff,
                                                 legacy_attr_map_f_segment_ff};
            OFS_ATTR_C_LOW: nxt_cfg_rdata = {24'h000000, legacy_attr_map_c_low_ff};
            default: nxt_cfg_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Access routing, registered one cycle after the request
   always_comb
   begin
      logic in_region;
      logic [1:0] attr;
      in_region = 1'b0;
      attr = 2'h0;
      nxt_route = '0;
      nxt_route.valid = ACC.valid;
      if (ACC.valid && ACC.is_io)
      begin
         // Unclaimed I/O is left for the downstream link
         nxt_route.pm_io_hit = pm_io_window_base_ff[POS_WIN_EN] &&
            ACC.addr[15:6] == pm_io_window_base_ff[15:6];
         nxt_route.target = DST_DOWN;
      end
      else if (ACC.valid)
      begin
         in_region = ACC.addr >= REGION_LO && ACC.addr <= REGION_HI;
         if (ACC.addr[31:16] == SEG_F_BASE)
         begin
            attr = legacy_attr_map_f_segment_ff[POS_UPPER +: 2];
         end
         else if (ACC.addr[31:14] == SEG_C4_BASE)
         begin
            attr = legacy_attr_map_c_low_ff[POS_UPPER +: 2];
         end
         else if (ACC.addr[31:14] == SEG_C0_BASE)
         begin
            attr = legacy_attr_map_c_low_ff[POS_LOWER +: 2];
         end
         else
         begin
            // Segments of the other attribute registers are treated as read-write DRAM
            attr = 2'h3;
         end
         if (!in_region || ACC.source == SRC_LINK || ACC.source == SRC_GFX)
         begin
            nxt_route.target = DST_DRAM;
         end
         else
         begin
            nxt_route.target = steer(attr, ACC.is_write);
         end
      end
   end

   // One register stage for config state, read data and route
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         pm_io_window_base_ff <= RST_PM_IO_WINDOW_BASE;
         legacy_attr_map_f_segment_ff <= RST_ATTR;
         legacy_attr_map_c_low_ff <= RST_ATTR;
         cfg_rdata_ff <= 32'h0000_0000;
         route_ff <= '0;
      end
      else
      begin
         pm_io_window_base_ff <= nxt_pm_io_window_base;
         legacy_attr_map_f_segment_ff <= nxt_legacy_attr_map_f_segment;
         legacy_attr_map_c_low_ff <= nxt_legacy_attr_map_c_low;
         cfg_rdata_ff <= nxt_cfg_rdata;
         route_ff <= nxt_route;
      end
   end

   // Outputs straight from flops, so no decode glitch reaches the fabric
   assign CFG_RDATA = cfg_rdata_ff;
   assign ROUTE = route_ff;

   // Upper F field written with a given code
   sequence s_f_write(logic [1:0] v);
      CFG_WR && CFG_ADDR == OFS_ATTR_F_SEGMENT && CFG_BE[0] && CFG_WDATA[5:4] == v;
   endsequence

   // Lower C register written through its own offset
   sequence s_c_write;
      CFG_WR && CFG_ADDR == OFS_ATTR_C_LOW && CFG_BE[0];
   endsequence

   // Register storage, steering and window claim checks

   AST_RSVD_ZERO: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (pm_io_window_base_ff & ~MASK_PM_IO_WINDOW_BASE) == 32'h0)
      else $error("window base reserved bits set");
   AST_NO_CLAIM_DISABLED: assert property (@(posedge CORE_CLK) disable iff (SRST)
      ROUTE.pm_io_hit |-> $past(pm_io_window_base_ff[POS_WIN_EN]))
      else $error("window claimed while disabled");
   AST_SAME_WRITE: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (CFG_WR && CFG_ADDR == OFS_PM_IO_WINDOW_BASE && CFG_BE[0] && CFG_BE[1] && CFG_WDATA[0])
      |=> pm_io_window_base_ff[15:0] == ($past(CFG_WDATA[15:0]) & 16'hffc1))
      else $error("base and enable not taken together");
   AST_READ_STEER: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && !ACC.is_write && ACC.source == SRC_CPU &&
       ACC.addr[31:16] == SEG_F_BASE && legacy_attr_map_f_segment_ff[4])
      |=> ROUTE.target == DST_DRAM)
      else $error("read not claimed for DRAM");
   AST_WRITE_STEER: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && ACC.is_write && ACC.source == SRC_PCI &&
       ACC.addr[31:14] == SEG_C0_BASE && !legacy_attr_map_c_low_ff[1])
      |=> ROUTE.target == DST_DOWN)
      else $error("write not forwarded downstream");
   AST_ENCODE_01: assert property (@(posedge CORE_CLK) disable iff (SRST)
      s_f_write(2'h1) ##1 (ACC.valid && !ACC.is_io && ACC.is_write &&
       ACC.source == SRC_CPU && ACC.addr[31:16] == SEG_F_BASE) |=> ROUTE.target == DST_DOWN)
      else $error("encoding 01 write misrouted");
   AST_C4_FIELD: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (CFG_WR && CFG_ADDR == OFS_ATTR_C_LOW && CFG_BE[0]) |=>
      legacy_attr_map_c_low_ff[5:4] == $past(CFG_WDATA[5:4]) &&
      legacy_attr_map_c_low_ff[7:6] == 2'h0 && legacy_attr_map_c_low_ff[3:2] == 2'h0)
      else $error("upper C field not stored");
   AST_F_RSVD: assert property (@(posedge CORE_CLK) disable iff (SRST)
      legacy_attr_map_f_segment_ff[3:0] == 4'h0)
      else $error("F register low bits set");
   AST_LINK_DRAM: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && (ACC.source == SRC_LINK || ACC.source == SRC_GFX))
      |=> ROUTE.target == DST_DRAM)
      else $error("link access not sent to DRAM");
   AST_WINDOW_HIT: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && ACC.is_io && pm_io_window_base_ff[0] &&
       ACC.addr[15:6] == pm_io_window_base_ff[15:6]) |=> ROUTE.pm_io_hit)
      else $error("window access not claimed");
   AST_C0_FIELD: assert property (@(posedge CORE_CLK) disable iff (SRST)
      s_c_write |=> legacy_attr_map_c_low_ff[1:0] == $past(CFG_WDATA[1:0]))
      else $error("lower C field not stored");
   AST_ENCODE_10: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && !ACC.is_write && !ACC.source[1] &&
       ACC.addr[31:14] == SEG_C4_BASE && legacy_attr_map_c_low_ff[5:4] == 2'h2)
      |=> ROUTE.target == DST_DOWN)
      else $error("encoding 10 read misrouted");
   AST_ENCODE_11: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && !ACC.source[1] && ACC.addr[31:16] == SEG_F_BASE &&
       legacy_attr_map_f_segment_ff[5:4] == 2'h3) |=> ROUTE.target == DST_DRAM)
      else $error("encoding 11 access misrouted");
   AST_PCI_READ: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && !ACC.is_io && !ACC.is_write && ACC.source == SRC_PCI &&
       ACC.addr[31:14] == SEG_C4_BASE && legacy_attr_map_c_low_ff[4])
      |=> ROUTE.target == DST_DRAM)
      else $error("initiator read not claimed");
   AST_IO_MISS: assert property (@(posedge CORE_CLK) disable iff (SRST)
      (ACC.valid && ACC.is_io && ACC.addr[15:6] != pm_io_window_base_ff[15:6])
      |=> !ROUTE.pm_io_hit)
      else $error("access outside window claimed");
   AST_RESET_CLEAR: assert property (@(posedge CORE_CLK)
      SRST |=> pm_io_window_base_ff == RST_PM_IO_WINDOW_BASE &&
      legacy_attr_map_f_segment_ff == RST_ATTR && legacy_attr_map_c_low_ff == RST_ATTR)
      else $error("registers not cleared by reset");
endmodule

// ### tb/far_side_model.sv
`timescale 1ns/10ps
// Issuer of processor, initiator, link and graphics accesses
module far_side_model
   import legacy_decode_pkg::*;
(
   input wire logic clk,
   output access_s acc
);
   initial acc = '0;
   // Launch on the falling edge, hold one whole cycle
   task automatic issue(input access_s a);
      @(negedge clk);
      acc = a;
   endtask
   // Drop valid so no stale access is seen twice
   task automatic idle();
      @(negedge clk);
      acc = '0;
   endtask
endmodule

// ### tb/test_legacy_region_attribute_decode.sv
`timescale 1ns/10ps
module test_legacy_region_attribute_decode;
   import legacy_decode_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'hf;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] cfg_rdata;
   access_s acc;
   route_s route;
   route_s rq[$];
   logic [31:0] dq[$];
   logic [31:0] lfsr = 32'h509612b9;
   logic [7:0] f_seg = 8'h00;
   logic [7:0] c_low = 8'h00;
   logic [31:0] pm = 32'h0;
   logic [31:0] bases[5] = '{32'h000f0000, 32'h000c0000, 32'h000c4000, 32'h000d8000, 32'h1f000000};
   int errors = 0;
   int n_compared = 0;

   always #2.5 core_clk = ~core_clk;

   legacy_region_attribute_decode DUT (.CORE_CLK(core_clk), .SRST(srst), .CFG_WR(cfg_wr),
      .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
      .CFG_RDATA(cfg_rdata), .ACC(acc), .ROUTE(route));
   far_side_model far (.clk(core_clk), .acc(acc));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // Space outside the two registers behaves as read-write DRAM
   function automatic logic [1:0] seg_attr(input logic [31:0] a);
      if (a[31:16] == SEG_F_BASE) return f_seg[5:4];
      if (a[31:14] == SEG_C0_BASE) return c_low[1:0];
      if (a[31:14] == SEG_C4_BASE) return c_low[5:4];
      return 2'b11;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One-cycle strobe; for a read d is the expected data
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk);
      cfg_wr = wr;
      cfg_rd = !wr;
      cfg_addr = a;
      cfg_wdata = d;
      if (!wr)
         dq.push_back(d);
      @(negedge core_clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
   endtask
   // Note the expected route, then hand the access to the far side
   task automatic access(input logic io, input logic w, input logic [1:0] s, input logic [31:0] a);
      route_s e;
      logic [1:0] t;
      t = seg_attr(a);
      if (t != 2'b11)
         s[1] = 1'b0;
      e.valid = 1'b1;
      e.pm_io_hit = io && pm[0] && a[15:6] == pm[15:6];
      if (io || !(s[1] || (w ? t[1] : t[0])))
         e.target = DST_DOWN;
      else
         e.target = DST_DRAM;
      rq.push_back(e);
      far.issue(access_s'{1'b1, io, w, source_e'(s), a});
   endtask

   // Results are matched against the oldest pending note
   always @(posedge core_clk)
   begin
      #1;
      if (route.valid === 1'b1)
         check("route", {28'h0, route}, rq.size() ? {28'h0, rq.pop_front()} : 32'h0);
      if (cfg_rd === 1'b1)
         check("rdata", cfg_rdata, dq.size() ? dq.pop_front() : 32'hdead0000);
   end

   initial
   begin
      logic [31:0] r;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      cfg(1'b0, 8'h78, 32'h0);
      cfg(1'b0, 8'h90, 32'h0);
      cfg(1'b0, 8'h91, 32'h0);
      cfg(1'b1, 8'h40, rnd());
      cfg(1'b0, 8'h40, 32'h0);
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         // First passes walk every field code in all three fields
         if (i < 4)
         begin
            r[5:4] = i[1:0];
            r[9:8] = i[1:0];
            r[13:12] = i[1:0];
         end
         // Later passes drop random byte lanes of the pair
         cfg_be = (i < 4) ? 4'hf : r[19:16];
         cfg(1'b1, 8'h90, r);
         if (cfg_be[0])
            f_seg = r[7:0] & MASK_ATTR_F_SEGMENT;
         if (cfg_be[1])
            c_low = r[15:8] & MASK_ATTR_C_LOW;
         cfg_be = 4'hf;
         if (i > 3)
         begin
            r = rnd();
            cfg(1'b1, 8'h91, r);
            c_low = r[7:0] & MASK_ATTR_C_LOW;
         end
         cfg(1'b0, 8'h90, {16'h0, c_low, f_seg});
         cfg(1'b0, 8'h91, {24'h0, c_low});
         // Close the window before moving its base
         cfg(1'b1, 8'h78, pm & 32'hfffffffe);
         r = rnd();
         cfg(1'b1, 8'h78, r);
         pm = r & MASK_PM_IO_WINDOW_BASE;
         cfg(1'b0, 8'h78, pm);
         for (int k = 0; k < 5; k++)
         begin
            r = rnd();
            access(1'b0, r[0], r[2:1], bases[k] | {18'h0, r[16:3]});
         end
         access(1'b1, r[17], r[19:18], {16'h0, pm[15:6], r[25:20]});
         access(1'b1, r[26], 2'h1, {16'h0, pm[15:6] ^ 10'h200, r[31:26]});
         far.idle();
      end
      // Access right behind an attribute write must see the new code
      f_seg = 8'h10;
      fork
         cfg(1'b1, 8'h90, {16'h0, c_low, f_seg});
         begin
            @(negedge core_clk);
            access(1'b0, 1'b1, 2'h0, 32'h000f_8000);
         end
      join
      far.idle();
      // Mid-run reset must clear every register and close the window
      @(negedge core_clk);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      pm = 32'h0;
      f_seg = 8'h00;
      c_low = 8'h00;
      cfg(1'b0, 8'h78, 32'h0);
      cfg(1'b0, 8'h90, 32'h0);
      cfg(1'b0, 8'h91, 32'h0);
      access(1'b1, 1'b0, 2'h0, 32'h0000_0010);
      access(1'b0, 1'b0, 2'h0, 32'h000f_0000);
      far.idle();
      for (int n = 0; n < 10 && rq.size() + dq.size() > 0; n++)
         @(posedge core_clk);
      if (rq.size() + dq.size() > 0)
         check("drain", 32'h1, 32'h0);
      end_of_test();
   end
endmodule
